// File: src/scc_pkg.sv
// Constants for the system clock source controller.
// Assumes a classic Wishbone slave with 32-bit data and one clock domain.
package scc_pkg;
  localparam logic [7:0] ADR_CLOCK_CONTROL = 8'hc6;
  localparam logic [7:0] ADR_SLEEP_CONTROL = 8'hbe;
  localparam logic [7:0] CLOCK_CONTROL_RST = 8'hc9;
  localparam int BIT_SLOW_SEL = 7;
  localparam int BIT_SYS_SEL = 6;
  localparam int BIT_XTAL_STB = 6;
  localparam int BIT_RC_STB = 5;
  localparam int BIT_PD = 2;
  localparam logic [1:0] MODE_IDLE = 2'h0;
  localparam logic [1:0] MODE_DEEPEST = 2'h3;
  localparam int CLK_MHZ = 100;
  localparam int FIRST_CAL_US = 2000;
  localparam int LATER_CAL_US = 130;
  localparam int FIRST_CAL_CYC = FIRST_CAL_US * CLK_MHZ;
  localparam int LATER_CAL_CYC = LATER_CAL_US * CLK_MHZ;
  localparam int RC_CAL_CYC = 64;
  localparam int DIV_PLAIN = 750;
  localparam int DIV_USB = 1500;
endpackage

// File: src/scc_ctrl.sv
// System clock source controller: register file, source handover, calibration sequencing.
// Assumes oscillator stable inputs come from analog cells and are asynchronous.
//
// Local design decision: the Wishbone slave port.
`timescale 1ns/1ps
module scc_ctrl #(
  parameter bit USB_VARIANT = 1'b0,
  parameter int FIRST_CAL = scc_pkg::FIRST_CAL_CYC,
  parameter int LATER_CAL = scc_pkg::LATER_CAL_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic xtal_ready_i,
  input wire logic rc_ready_i,
  input wire logic sleep_enter_i,
  input wire logic wake_i,
  input wire logic deep_state_i,
  output logic xtal_en_o,
  output logic rc_en_o,
  output logic rc_cal_o,
  output logic slow_xtal_en_o,
  output logic slow_rc_en_o,
  output logic slow_cal_o,
  output logic sys_from_rc_o,
  output logic [11:0] slow_div_o,
  output logic sleep_ok_o,
  output logic [1:0] mode_o
);
  import scc_pkg::*;

  typedef enum logic [1:0] {SCC_IDLE, SCC_FIRST, SCC_LATER} scc_cal_e;

  logic [7:0] clock_control_reg_ff, nxt_clock_control_reg;
  logic [1:0] mode_ff, nxt_mode;
  logic pd_ff, nxt_pd;
  logic pd_pend_ff, nxt_pd_pend;
  logic cur_rc_ff, nxt_cur_rc;
  logic rccal_ff, nxt_rccal;
  logic [7:0] rccnt_ff, nxt_rccnt;
  logic wake_cal_ff, nxt_wake_cal;
  logic ack_ff, nxt_ack;
  logic [31:0] dat_ff, nxt_dat;
  scc_cal_e cal_ff, nxt_cal;
  logic [31:0] calcnt_ff, nxt_calcnt;
  logic first_done_ff, nxt_first_done;
  logic [1:0] xs_ff, rs_ff;
  logic xtal_stb, rc_stb, wr, rd, sel_toggle, sys_xtal;

  // Two-flop synchronisers for analog ready flags
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      xs_ff <= 2'h0;
      rs_ff <= 2'h0;
    end else begin
      xs_ff <= {xs_ff[0], xtal_ready_i & xtal_en_o};
      rs_ff <= {rs_ff[0], rc_ready_i & rc_en_o};
    end
  end
  assign xtal_stb = xs_ff[1];
  assign rc_stb = rs_ff[1];

  assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~ack_ff & wb_sel_i[0];
  assign rd = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign sys_xtal = ~clock_control_reg_ff[BIT_SYS_SEL];
  assign sel_toggle = wr && wb_adr_i == ADR_CLOCK_CONTROL &&
                      wb_dat_i[BIT_SYS_SEL] != clock_control_reg_ff[BIT_SYS_SEL];

  always_comb begin
    nxt_clock_control_reg = clock_control_reg_ff;
    nxt_mode = mode_ff;
    nxt_pd = pd_ff;
    nxt_pd_pend = pd_pend_ff;
    nxt_ack = rd;
    nxt_dat = 32'h0;
    if (wr && wb_adr_i == ADR_CLOCK_CONTROL) begin
      nxt_clock_control_reg = wb_dat_i[7:0];
    end
    if (wr && wb_adr_i == ADR_SLEEP_CONTROL) begin
      nxt_mode = wb_dat_i[1:0];
      if (wb_dat_i[BIT_PD] && (rccal_ff || cal_ff != SCC_IDLE)) begin
        nxt_pd_pend = 1'b1;
      end else begin
        nxt_pd = wb_dat_i[BIT_PD];
        nxt_pd_pend = 1'b0;
      end
    end
    if (!rccal_ff && cal_ff == SCC_IDLE && pd_pend_ff) begin
      nxt_pd = 1'b1;
      nxt_pd_pend = 1'b0;
    end
    if (sel_toggle) begin
      nxt_pd = 1'b0;
      nxt_pd_pend = 1'b0;
    end
    if (sleep_enter_i) begin
      nxt_mode = MODE_IDLE;
    end
    if (rd && !wb_we_i) begin
      if (wb_adr_i == ADR_CLOCK_CONTROL) begin
        nxt_dat = {24'h0, clock_control_reg_ff};
      end else if (wb_adr_i == ADR_SLEEP_CONTROL) begin
        nxt_dat = {25'h0, xtal_stb, rc_stb, 2'h0, pd_ff, mode_ff};
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      clock_control_reg_ff <= CLOCK_CONTROL_RST;
      mode_ff <= MODE_IDLE;
      pd_ff <= 1'b1;
      pd_pend_ff <= 1'b0;
      ack_ff <= 1'b0;
      dat_ff <= 32'h0;
    end else begin
      clock_control_reg_ff <= nxt_clock_control_reg;
      mode_ff <= nxt_mode;
      pd_ff <= nxt_pd;
      pd_pend_ff <= nxt_pd_pend;
      ack_ff <= nxt_ack;
      dat_ff <= nxt_dat;
    end
  end
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = dat_ff;
  assign mode_o = mode_ff;

  // Source handover and fast RC calibration; switch back to RC waits on slow calibration
  always_comb begin
    nxt_cur_rc = cur_rc_ff;
    nxt_rccal = rccal_ff;
    nxt_rccnt = rccnt_ff;
    nxt_wake_cal = wake_cal_ff;
    if (sleep_enter_i && sys_xtal) begin
      nxt_wake_cal = 1'b1;
    end
    if (sys_xtal && cur_rc_ff && xtal_stb) begin
      nxt_cur_rc = 1'b0;
      nxt_rccal = 1'b1;
      nxt_rccnt = 8'h0;
    end else if (!sys_xtal && !cur_rc_ff && rc_stb && cal_ff == SCC_IDLE) begin
      nxt_cur_rc = 1'b1;
    end
    if (wake_i && wake_cal_ff && sys_xtal) begin
      nxt_rccal = 1'b1;
      nxt_rccnt = 8'h0;
      nxt_wake_cal = 1'b0;
    end
    if (rccal_ff) begin
      nxt_rccnt = rccnt_ff + 8'h1;
      if (rccnt_ff == 8'(RC_CAL_CYC - 1)) begin
        nxt_rccal = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_rc_ff <= 1'b1;
      rccal_ff <= 1'b0;
      rccnt_ff <= 8'h0;
      wake_cal_ff <= 1'b0;
    end else begin
      cur_rc_ff <= nxt_cur_rc;
      rccal_ff <= nxt_rccal;
      rccnt_ff <= nxt_rccnt;
      wake_cal_ff <= nxt_wake_cal;
    end
  end

  // Continuous slow RC calibration
  always_comb begin
    nxt_cal = cal_ff;
    nxt_calcnt = calcnt_ff;
    nxt_first_done = first_done_ff;
    if (cur_rc_ff) begin
      nxt_first_done = 1'b0;
    end
    case (cal_ff)
      SCC_IDLE: begin
        if (!cur_rc_ff && xtal_stb && !deep_state_i && clock_control_reg_ff[BIT_SLOW_SEL] && sys_xtal) begin
          nxt_cal = first_done_ff ? SCC_LATER : SCC_FIRST;
          nxt_calcnt = 32'h0;
        end
      end
      SCC_FIRST, SCC_LATER: begin
        nxt_calcnt = calcnt_ff + 32'h1;
        if (calcnt_ff >= 32'((cal_ff == SCC_FIRST ? FIRST_CAL : LATER_CAL) - 1)) begin
          nxt_cal = SCC_IDLE;
          nxt_first_done = 1'b1;
        end
      end
      default: nxt_cal = SCC_IDLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cal_ff <= SCC_IDLE;
      calcnt_ff <= 32'h0;
      first_done_ff <= 1'b0;
    end else begin
      cal_ff <= nxt_cal;
      calcnt_ff <= nxt_calcnt;
      first_done_ff <= nxt_first_done;
    end
  end

  // unselected oscillator stays up while powerdown is 0; the RC also stays up during fast calibration
  assign xtal_en_o = sys_xtal | ~cur_rc_ff | ~pd_ff;
  assign rc_en_o = ~sys_xtal | cur_rc_ff | ~pd_ff | rccal_ff;
  assign rc_cal_o = rccal_ff;
  assign sys_from_rc_o = cur_rc_ff; // mux flips on one registered edge only
  assign slow_rc_en_o = clock_control_reg_ff[BIT_SLOW_SEL];
  assign slow_xtal_en_o = ~clock_control_reg_ff[BIT_SLOW_SEL];
  assign slow_cal_o = cal_ff != SCC_IDLE;
  assign slow_div_o = USB_VARIANT ? 12'(DIV_USB) : 12'(DIV_PLAIN);
  assign sleep_ok_o = cal_ff == SCC_IDLE;

  a_deep_clear: assert property (@(posedge clk_i) disable iff (rst_i)
    sleep_enter_i |=> mode_ff == MODE_IDLE) else $error("mode not cleared");
  a_hold_source: assert property (@(posedge clk_i) disable iff (rst_i)
    (cur_rc_ff && !xtal_stb) |=> cur_rc_ff) else $error("switched early");
  a_pd_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
    sel_toggle |=> !pd_ff) else $error("powerdown kept");
  a_slow_excl: assert property (@(posedge clk_i) disable iff (rst_i)
    !(slow_rc_en_o && slow_xtal_en_o)) else $error("both slow on");
  a_cal_on_xtal: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(rccal_ff) |-> !cur_rc_ff) else $error("fast cal off crystal");
  a_slow_cal_xtal: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(slow_cal_o) |-> $past(xtal_stb)) else $error("slow cal unstable");
  a_back_waits: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(cur_rc_ff) |-> $past(cal_ff) == SCC_IDLE) else $error("switch in cal");
  a_pd_unsel: assert property (@(posedge clk_i) disable iff (rst_i)
    (pd_ff && !cur_rc_ff && sys_xtal && !rccal_ff) |-> !rc_en_o) else $error("rc on");
  c_to_xtal: cover property (@(posedge clk_i) $fell(cur_rc_ff));
  c_to_rc: cover property (@(posedge clk_i) $rose(cur_rc_ff));
  c_slow_cal: cover property (@(posedge clk_i) $fell(slow_cal_o));
endmodule

// File: verification/system_clock_source_control_tb.sv
// Self-checking bench for the clock source controller over Wishbone.
// Assumes scc_ctrl with shortened slow calibration counts and a 100 MHz clock.
`timescale 1ns/1ps
module system_clock_source_control_tb;
  import scc_pkg::*;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0;
  logic [31:0] wdat = 0, rdat, dat_o, tmp;
  logic ack, xr = 0, rr = 0, se = 0, wk = 0, ds = 0;
  logic xen, ren, rcal, sxen, sren, scal, sysrc, sok;
  logic [11:0] div;
  logic [1:0] mode;
  int failures = 0, n_compared = 0, seed = 32'hcc644040, i;
  scc_ctrl #(.FIRST_CAL(50), .LATER_CAL(20)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .xtal_ready_i(xr), .rc_ready_i(rr), .sleep_enter_i(se), .wake_i(wk),
    .deep_state_i(ds), .xtal_en_o(xen), .rc_en_o(ren), .rc_cal_o(rcal),
    .slow_xtal_en_o(sxen), .slow_rc_en_o(sren), .slow_cal_o(scal),
    .sys_from_rc_o(sysrc), .slow_div_o(div), .sleep_ok_o(sok), .mode_o(mode));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (failures == 0 && n_compared > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // Fast oscillator enables {crystal, rc} once no handover is pending
  function automatic logic [1:0] fast_en(input logic pd, input logic from_rc);
    return pd ? {~from_rc, from_rc} : 2'b11;
  endfunction
  // Slow oscillator enables {crystal, rc}: exactly one source runs
  function automatic logic [1:0] slow_en(input logic sel);
    return {~sel, sel};
  endfunction
  // Called at a rising edge; holds the request until ack is seen high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n = 0;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    wdat <= d;
    // Sample ack and data at the rising edge itself, then release there
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) begin
      failures++;
      final_report();
    end
    rdat = dat_o;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge clk_i);
  endtask
  function automatic logic pick(input int k);
    case (k)
      0: return sysrc;
      1: return rcal;
      default: return scal;
    endcase
  endfunction
  task automatic wait_on(input int k, input logic v);
    int n = 0;
    while (pick(k) !== v && n < 400) begin
      @(negedge clk_i);
      n++;
    end
    if (n >= 400) begin
      failures++;
      final_report();
    end
    @(posedge clk_i);
  endtask
  task automatic idle(input int c);
    repeat (c) @(posedge clk_i);
  endtask
  initial begin
    idle(16);
    rst_i <= 0;
    idle(1);
    wb(0, ADR_CLOCK_CONTROL, 0);
    check(rdat, 32'hc9);
    wb(0, ADR_SLEEP_CONTROL, 0);
    check(rdat, 32'h04);
    check({xen, ren}, fast_en(1'b1, 1'b1));
    check({sxen, sren}, slow_en(1'b1));
    check(div, 12'd750);
    for (i = 0; i < 4; i++) begin
      tmp = $random(seed);
      if (tmp[7:0] == ADR_CLOCK_CONTROL || tmp[7:0] == ADR_SLEEP_CONTROL) tmp[7:0] = 8'h00;
      wb(0, tmp[7:0], 0);
      check(rdat, 0);
    end
    rr <= 1;
    // Crystal not ready yet, so the old source must hold
    wb(1, ADR_CLOCK_CONTROL, 32'h89);
    idle(20);
    check(sysrc, 1'b1);
    wb(0, ADR_SLEEP_CONTROL, 0);
    check(rdat[BIT_PD], 1'b0);
    xr <= 1;
    wait_on(0, 1'b0);
    check(rcal, 1'b1);
    wait_on(2, 1'b1);
    check(sok, 1'b0);
    wb(0, ADR_SLEEP_CONTROL, 0);
    check(rdat, 32'h60);
    check({xen, ren}, fast_en(1'b0, 1'b0));
    wb(1, ADR_SLEEP_CONTROL, {30'h0, MODE_DEEPEST});
    check(mode, MODE_DEEPEST);
    ds <= 1;
    se <= 1;
    idle(1);
    se <= 0;
    idle(1);
    check(mode, MODE_IDLE);
    wait_on(2, 1'b0);
    idle(30);
    check(scal, 1'b0);
    ds <= 0;
    wk <= 1;
    idle(1);
    wk <= 0;
    wait_on(1, 1'b1);
    // Mode cleared by software after wake; powerdown asked for mid-calibration
    wb(1, ADR_SLEEP_CONTROL, 32'h04);
    wb(0, ADR_SLEEP_CONTROL, 0);
    check(rdat[BIT_PD], 1'b0);
    check(rdat[1:0], MODE_IDLE);
    wait_on(1, 1'b0);
    idle(25);
    wb(0, ADR_SLEEP_CONTROL, 0);
    check(rdat[BIT_PD], 1'b1);
    rr <= 0;
    wb(1, ADR_CLOCK_CONTROL, 32'hc9);
    idle(20);
    check(sysrc, 1'b0);
    rr <= 1;
    wait_on(0, 1'b1);
    check(sok, 1'b1);
    wb(1, ADR_SLEEP_CONTROL, 32'h04);
    idle(2);
    check({xen, ren}, fast_en(1'b1, 1'b1));
    for (i = 0; i < 8; i++) begin
      tmp = $random(seed);
      tmp = {24'h0, tmp[7], 1'b1, tmp[5:0]}; // no radio use here
      wb(1, ADR_CLOCK_CONTROL, tmp);
      wb(0, ADR_CLOCK_CONTROL, 0);
      check(rdat, tmp);
      idle(3);
      check({sxen, sren}, slow_en(tmp[BIT_SLOW_SEL]));
    end
    final_report();
  end
endmodule
